// >>> hdl/ums_defines.vh
// constants for the four-channel serial modem-signal and interrupt block
// Functional notes
// - low carrier detect reads as status bit 7
// - set ready reads bit 5, no data effect
// - terminal ready low while control bit 0 set
// - reset drives terminal ready high
// - interrupt pin driven only while gate bit set or force enable input high
// - force enable input drives all interrupt pins
// - interrupt pin high for enabled pending interrupt
// - four sources: error, data/timeout, empty, modem
// - reset leaves interrupt pins disabled
// - read returns addressed register of selected channel
// - write stores data into addressed channel register
// - reset clears registers, sets outputs defined
// - transmit and receive paths disabled during reset
// - low ring indicator reads as status bit 6
// - setting control bit drives request to send low
// - request to send high on reset, loopback, clear
// - auto mode: receiver forces request to send high
// - three register-select bits choose the register
// - only the selected channel answers
// - reset puts transmit output in marking state
// - loopback feeds transmit back into receiver
`ifndef UMS_DEFINES_VH
`define UMS_DEFINES_VH

// ----------------------------------------------------------------
// address map
// ----------------------------------------------------------------
`define UMS_ADDR_REG_LSB 2
`define UMS_ADDR_CH_LSB  5
`define UMS_ADDR_TOP_LSB 7
`define UMS_REG_DATA     3'h0
`define UMS_REG_IEN      3'h1
`define UMS_REG_IID      3'h2
`define UMS_REG_MCTL     3'h4
`define UMS_REG_MSTAT    3'h6
`define UMS_REG_SCRATCH  3'h7

// ----------------------------------------------------------------
// modem control fields
// ----------------------------------------------------------------
`define UMS_MC_TERM      0
`define UMS_MC_RTS       1
`define UMS_MC_OUT1      2
`define UMS_MC_GATE      3
`define UMS_MC_LOOP      4
`define UMS_MC_AUTORTS   5
`define UMS_MC_RESET     8'h00

// ----------------------------------------------------------------
// interrupt enable fields and identification codes
// ----------------------------------------------------------------
`define UMS_IE_RXD       0
`define UMS_IE_THRE      1
`define UMS_IE_LINE      2
`define UMS_IE_MODEM     3
`define UMS_IE_RESET     8'h00
`define UMS_ID_NONE      4'h1
`define UMS_ID_LINE      4'h6
`define UMS_ID_RXD       4'h4
`define UMS_ID_TMO       4'hc
`define UMS_ID_THRE      4'h2
`define UMS_ID_MODEM     4'h0

`endif

// >>> hdl/ums_irq_prio.v
// interrupt source priority encoder for one channel
`include "ums_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module ums_irq_prio
(
  // enabled pending sources
  input  wire       src_line,
  input  wire       src_rxd,
  input  wire       src_tmo,
  input  wire       src_thre,
  input  wire       src_modem,
  // result
  output reg  [3:0] id_code,
  output wire       any
);
  assign any = src_line | src_rxd | src_tmo | src_thre | src_modem;

  // line error outranks data, data outranks empty, modem is last
  always @*
  begin
    if (src_line)
      id_code = `UMS_ID_LINE;
    else if (src_rxd)
      id_code = `UMS_ID_RXD;
    else if (src_tmo)
      id_code = `UMS_ID_TMO;
    else if (src_thre)
      id_code = `UMS_ID_THRE;
    else if (src_modem)
      id_code = `UMS_ID_MODEM;
    else
      id_code = `UMS_ID_NONE;
  end
endmodule
`default_nettype wire

// >>> hdl/ums_rst_sync.v
// reset release synchroniser
`timescale 1ns/10ps
`default_nettype none
module ums_rst_sync
(
  // clock and raw reset
  input  wire mclk,
  input  wire arst_n,
  // synchronised reset
  output wire srst_n
);
  reg stage1;
  reg stage2;

  // assertion is immediate, release waits two edges
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
    end
    else
    begin
      stage1 <= 1'b1;
      stage2 <= stage1;
    end
  end

  assign srst_n = stage2;
endmodule
`default_nettype wire

// >>> hdl/ums_top.v
// four-channel modem signal, interrupt pin and register block
`include "ums_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module ums_top
#(
  parameter NUM_CH = 4
)
(
  // clock and reset
  input  wire                  mclk,
  input  wire                  arst_n,
  // ahb-lite slave
  input  wire                  hsel,
  input  wire [31:0]           haddr,
  input  wire [1:0]            htrans,
  input  wire                  hwrite,
  input  wire [2:0]            hsize,
  input  wire [31:0]           hwdata,
  input  wire                  hready,
  output reg                   hreadyout,
  output reg  [31:0]           hrdata,
  output reg                   hresp,
  // global interrupt override
  input  wire                  interrupt_force_enable,
  // modem status inputs, active low
  input  wire [NUM_CH-1:0]     carrier_detect_n,
  input  wire [NUM_CH-1:0]     set_ready_n,
  input  wire [NUM_CH-1:0]     ring_indicator_n,
  input  wire [NUM_CH-1:0]     clear_to_send_n,
  // modem control outputs, active low
  output wire [NUM_CH-1:0]     terminal_ready_n,
  output wire [NUM_CH-1:0]     request_to_send_n,
  // three-state interrupt pins
  output wire [NUM_CH-1:0]     channel_irq,
  output wire [NUM_CH-1:0]     channel_irq_oe_n,
  // serial pins and framing path
  input  wire [NUM_CH-1:0]     serial_rx,
  output wire [NUM_CH-1:0]     serial_tx,
  input  wire [NUM_CH-1:0]     tx_shift_bit,
  output wire [NUM_CH-1:0]     rx_shift_bit,
  // receiver and transmitter status
  input  wire [NUM_CH*8-1:0]   rx_data,
  input  wire [NUM_CH-1:0]     rx_data_avail,
  input  wire [NUM_CH-1:0]     rx_timeout,
  input  wire [NUM_CH-1:0]     rx_line_error,
  input  wire [NUM_CH-1:0]     rx_above_threshold,
  input  wire [NUM_CH-1:0]     fifo_mode,
  input  wire [NUM_CH-1:0]     tx_holding_empty,
  // datapath strobes
  output wire [NUM_CH-1:0]     tx_load,
  output wire [NUM_CH*8-1:0]   tx_byte,
  output wire [NUM_CH-1:0]     rx_unload
);

  // ----------------------------------------------------------------
  // reset
  // ----------------------------------------------------------------
  wire srst_n;

  ums_rst_sync u_rst
  (
    .mclk   (mclk),
    .arst_n (arst_n),
    .srst_n (srst_n)
  );

  // ----------------------------------------------------------------
  // ahb-lite address phase capture
  // ----------------------------------------------------------------
  reg        ap_wr;
  reg        ap_rd;
  reg        ap_map;
  reg [1:0]  ap_ch;
  reg [2:0]  ap_idx;
  wire       ap_take;
  wire       addr_hit;
  wire       read_strobe_n;
  wire       write_strobe_n;
  wire [NUM_CH*8-1:0] rd_bus;
  reg  [7:0] rd_byte;

  assign ap_take  = hsel & hready & htrans[1];
  // only aligned words inside the four channel windows below 0x80 decode; the rest read 0
  assign addr_hit = (haddr[31:`UMS_ADDR_TOP_LSB] == 25'h0000000) &
                    (haddr[1:0] == 2'b00);

  always @(posedge mclk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      ap_wr  <= 1'b0;
      ap_rd  <= 1'b0;
      ap_map <= 1'b0;
      ap_ch  <= 2'h0;
      ap_idx <= 3'h0;
    end
    else
    begin
      ap_wr <= ap_take & hwrite;
      ap_rd <= ap_take & ~hwrite;
      if (ap_take)
      begin
        ap_map <= addr_hit;
        ap_ch  <= haddr[`UMS_ADDR_CH_LSB+1:`UMS_ADDR_CH_LSB];
        ap_idx <= haddr[`UMS_ADDR_REG_LSB+2:`UMS_ADDR_REG_LSB];
      end
    end
  end

  // bus transfers stand in for the strobe pins of a parallel bus
  assign read_strobe_n  = ~(ap_rd & ap_map);
  assign write_strobe_n = ~(ap_wr & ap_map);

  // reads take one wait state so hrdata comes from a flop
  always @*
  begin
    rd_byte = 8'h00;
    if (!read_strobe_n)
      rd_byte = rd_bus[ap_ch*8 +: 8];
  end

  always @(posedge mclk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h00000000;
      hresp     <= 1'b0;
    end
    else
    begin
      hresp <= 1'b0;
      if (ap_take & ~hwrite)
        hreadyout <= 1'b0;
      else
        hreadyout <= 1'b1;
      if (ap_rd)
        hrdata <= {24'h000000, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // per-channel registers and pins
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1)
    begin : ch
      reg  [7:0] ien;
      reg  [7:0] mctl;
      reg  [7:0] scratch;
      reg  [3:0] delta;
      reg  [3:0] prev_act;
      reg        thre_pend;
      reg        prev_empty;
      reg        irq;
      reg        irq_oe_n;
      reg        term_n;
      reg        rts_n;
      reg        tx_pin;
      reg        rx_pin;
      reg        load;
      reg  [7:0] load_byte;
      reg        unload;
      reg  [7:0] rd_val;
      reg  [3:0] act;
      reg  [3:0] delta_set;
      wire       sel_rd;
      wire       sel_wr;
      wire       loop;
      wire       msr_rd;
      wire       iid_rd;
      wire [3:0] id_code;
      wire       any;

      assign sel_rd = ~read_strobe_n & (ap_ch == g);
      assign sel_wr = ~write_strobe_n & (ap_ch == g);
      assign loop   = mctl[`UMS_MC_LOOP];
      assign msr_rd = sel_rd & (ap_idx == `UMS_REG_MSTAT);
      assign iid_rd = sel_rd & (ap_idx == `UMS_REG_IID);

      // status as active-high levels: cd, ri, dsr, cts
      always @*
      begin
        act = 4'h0;
        delta_set = 4'h0;
        if (loop)
          act = {mctl[`UMS_MC_GATE], mctl[`UMS_MC_OUT1],
                 mctl[`UMS_MC_TERM], mctl[`UMS_MC_RTS]};
        else
          act = {~carrier_detect_n[g], ~ring_indicator_n[g],
                 ~set_ready_n[g], ~clear_to_send_n[g]};
        delta_set[3] = act[3] ^ prev_act[3];
        delta_set[2] = prev_act[2] & ~act[2];
        delta_set[1] = act[1] ^ prev_act[1];
        delta_set[0] = act[0] ^ prev_act[0];
      end

      ums_irq_prio u_prio
      (
        .src_line  (rx_line_error[g] & ien[`UMS_IE_LINE]),
        .src_rxd   (rx_data_avail[g] & ien[`UMS_IE_RXD]),
        .src_tmo   (rx_timeout[g] & fifo_mode[g] & ien[`UMS_IE_RXD]),
        .src_thre  (thre_pend & ien[`UMS_IE_THRE]),
        .src_modem ((|delta) & ien[`UMS_IE_MODEM]),
        .id_code   (id_code),
        .any       (any)
      );

      always @*
      begin
        rd_val = 8'h00;
        case (ap_idx)
          `UMS_REG_DATA:    rd_val = rx_data[g*8 +: 8];
          `UMS_REG_IEN:     rd_val = ien;
          `UMS_REG_IID:     rd_val = {{2{fifo_mode[g]}}, 2'b00, id_code};
          `UMS_REG_MCTL:    rd_val = mctl;
          `UMS_REG_MSTAT:   rd_val = {act, delta};
          `UMS_REG_SCRATCH: rd_val = scratch;
          default:          rd_val = 8'h00;
        endcase
      end
      assign rd_bus[g*8 +: 8] = rd_val;

      // register file; reset clears it and parks every pin
      always @(posedge mclk or negedge srst_n)
      begin
        if (!srst_n)
        begin
          ien        <= `UMS_IE_RESET;
          mctl       <= `UMS_MC_RESET;
          scratch    <= 8'h00;
          delta      <= 4'h0;
          prev_act   <= 4'h0;
          thre_pend  <= 1'b0;
          prev_empty <= 1'b0;
          irq        <= 1'b0;
          irq_oe_n   <= 1'b1;
          term_n     <= 1'b1;
          rts_n      <= 1'b1;
          tx_pin     <= 1'b1;
          rx_pin     <= 1'b1;
          load       <= 1'b0;
          load_byte  <= 8'h00;
          unload     <= 1'b0;
        end
        else
        begin
          if (sel_wr)
          begin
            case (ap_idx)
              `UMS_REG_IEN:     ien     <= {4'h0, hwdata[3:0]};
              `UMS_REG_MCTL:    mctl    <= {2'b00, hwdata[5:0]};
              `UMS_REG_SCRATCH: scratch <= hwdata[7:0];
              default:          scratch <= scratch;
            endcase
          end
          load      <= sel_wr & (ap_idx == `UMS_REG_DATA);
          unload    <= sel_rd & (ap_idx == `UMS_REG_DATA);
          if (sel_wr & (ap_idx == `UMS_REG_DATA))
            load_byte <= hwdata[7:0];
          // a change in the same cycle as the status read is kept
          prev_act   <= act;
          delta      <= (delta & {4{~msr_rd}}) | delta_set;
          prev_empty <= tx_holding_empty[g];
          // empty flag clears on a data write or when it is reported
          thre_pend  <= (thre_pend &
                         ~(sel_wr & (ap_idx == `UMS_REG_DATA)) &
                         ~(iid_rd & (id_code == `UMS_ID_THRE))) |
                        (tx_holding_empty[g] & ~prev_empty);
          irq      <= any;
          irq_oe_n <= ~(interrupt_force_enable | mctl[`UMS_MC_GATE]);
          term_n   <= ~mctl[`UMS_MC_TERM];
          rts_n    <= ~(mctl[`UMS_MC_RTS] & ~loop &
                        ~(mctl[`UMS_MC_AUTORTS] & rx_above_threshold[g]));
          // loopback holds the pin marking and wraps the shifter inward
          tx_pin   <= loop | tx_shift_bit[g];
          rx_pin   <= loop ? tx_shift_bit[g] : serial_rx[g];
        end
      end

      assign channel_irq[g]       = irq;
      assign channel_irq_oe_n[g]  = irq_oe_n;
      assign terminal_ready_n[g]  = term_n;
      assign request_to_send_n[g] = rts_n;
      assign serial_tx[g]         = tx_pin;
      assign rx_shift_bit[g]      = rx_pin;
      assign tx_load[g]           = load;
      assign tx_byte[g*8 +: 8]    = load_byte;
      assign rx_unload[g]         = unload;
    end
  endgenerate

endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the modem signal and interrupt pin block
`include "ums_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        mclk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        force_en = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdv, rxd = 32'h7700;
  logic [3:0]  cd_n = 4'hf, ri_n = 4'hf, srx = 4'hf, tsb = 4'hf;
  logic [3:0]  avail = 4'h0, tmo = 4'h0, lerr = 4'h0, thr = 4'h0;
  logic [3:0]  empty = 4'h0, fifo = 4'h1;
  logic [31:0] ids [5] = '{`UMS_ID_LINE, `UMS_ID_RXD, `UMS_ID_TMO,
                           `UMS_ID_THRE, `UMS_ID_MODEM};
  wire         hreadyout, hresp;
  wire  [31:0] hrdata, tx_byte;
  wire  [3:0]  dtr_n, rts_n, dsr_n, cts_n, irq, oe_n, stx, rsb, txl, rxu;
  int          n_errors = 0, checks_done = 0, cyc = 0;

  ums_top DUT (.mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .interrupt_force_enable(force_en),
    .carrier_detect_n(cd_n), .set_ready_n(dsr_n), .ring_indicator_n(ri_n),
    .clear_to_send_n(cts_n), .terminal_ready_n(dtr_n),
    .request_to_send_n(rts_n), .channel_irq(irq), .channel_irq_oe_n(oe_n),
    .serial_rx(srx), .serial_tx(stx), .tx_shift_bit(tsb),
    .rx_shift_bit(rsb), .rx_data(rxd), .rx_data_avail(avail),
    .rx_timeout(tmo), .rx_line_error(lerr), .rx_above_threshold(thr),
    .fifo_mode(fifo), .tx_holding_empty(empty), .tx_load(txl),
    .tx_byte(tx_byte), .rx_unload(rxu));
  ums_modem #(.NUM_CH(4), .LAT(2)) u_modem (.mclk(mclk),
    .terminal_ready_n(dtr_n), .request_to_send_n(rts_n),
    .set_ready_n(dsr_n), .clear_to_send_n(cts_n));

  initial
  begin
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // one whole-word transfer; the wait ends only on the slave's ready
  task automatic xfer(input logic w, input logic [31:0] a, d);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= a;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic rd(input string nm, input logic [31:0] a, e, m);
    xfer(1'b0, a, 32'h0);
    chk(nm, e & m, rdv & m);
  endtask
  function automatic logic [31:0] ra(input int c, input logic [2:0] r);
    return {25'h0, c[1:0], r, 2'h0};
  endfunction

  initial
  begin
    tick(12);
    chk("rst_pins", 32'hffff, {16'h0, dtr_n, rts_n, oe_n, stx});
    arst_n <= 1'b1;
    tick(3);
    for (int c = 0; c < 4; c++)
    begin
      rd("mctl_rst", ra(c, `UMS_REG_MCTL), 32'h0, 32'hff);
      xfer(1'b1, ra(c, `UMS_REG_SCRATCH), 32'ha0 + c);
      xfer(1'b1, ra(c, `UMS_REG_MCTL), 32'h3);
      cd_n[c] <= 1'b0;
      ri_n[c] <= ~c[0];
      tick(2);
      chk("dtr_on", (32'hf << (c + 1)) & 32'hf, {28'h0, dtr_n});
      chk("rts_on", (32'hf << (c + 1)) & 32'hf, {28'h0, rts_n});
      tick(3);
      rd("msr", ra(c, `UMS_REG_MSTAT), 32'hb0 | (c[0] << 6), 32'hf0);
    end
    for (int c = 0; c < 4; c++)
      rd("scratch", ra(c, `UMS_REG_SCRATCH), 32'ha0 + c, 32'hffffffff);
    xfer(1'b1, 32'h80, 32'h55);
    rd("unmapped_wr", ra(0, `UMS_REG_SCRATCH), 32'ha0, 32'hff);
    rd("unmapped_rd", ra(0, 3'h3), 32'h0, 32'hffffffff);
    chk("hresp", 32'h0, {31'h0, hresp});
    xfer(1'b1, ra(0, `UMS_REG_MCTL), 32'h0);
    tick(2);
    chk("dtr_off", 32'h1, {28'h0, dtr_n});
    rd("rx_byte", ra(1, `UMS_REG_DATA), 32'h77, 32'hff);
    chk("rx_unload", 32'h2, {28'h0, rxu});
    xfer(1'b1, ra(3, `UMS_REG_DATA), 32'h3c);
    tick(1);
    chk("tx_load", 32'h8, {28'h0, txl});
    tick(1);
    chk("tx_byte", 32'h3c, {24'h0, tx_byte[31:24]});
    $display("test registers done");
    avail[0] <= 1'b1;
    xfer(1'b1, ra(0, `UMS_REG_IEN), 32'hf);
    tick(2);
    chk("irq_hiz", 32'hf, {28'h0, oe_n});
    force_en <= 1'b1;
    tick(2);
    chk("irq_force", 32'h0, {28'h0, oe_n});
    force_en <= 1'b0;
    xfer(1'b1, ra(0, `UMS_REG_MCTL), 32'h8);
    tick(2);
    chk("irq_gate", 32'he, {28'h0, oe_n});
    xfer(1'b0, ra(0, `UMS_REG_MSTAT), 32'h0);
    for (int k = 0; k < 5; k++)
    begin
      lerr[0]  <= (k == 0);
      avail[0] <= (k == 1);
      tmo[0]   <= (k == 2);
      empty[0] <= (k == 3);
      if (k == 4)
        cd_n[0] <= 1'b1;
      tick(3);
      chk("irq_src", 32'h1, {31'h0, irq[0]});
      rd("iid", ra(0, `UMS_REG_IID), ids[k], 32'hf);
      xfer(1'b0, ra(0, `UMS_REG_MSTAT), 32'h0);
    end
    tick(3);
    chk("irq_idle", 32'h0, {31'h0, irq[0]});
    $display("test interrupts done");
    tsb[1] <= 1'b0;
    xfer(1'b1, ra(1, `UMS_REG_MCTL), 32'h13);
    tick(2);
    chk("loop_pins", 32'h6, {29'h0, rts_n[1], stx[1], rsb[1]});
    rd("loop_msr", ra(1, `UMS_REG_MSTAT), 32'h30, 32'hf0);
    xfer(1'b1, ra(2, `UMS_REG_MCTL), 32'h22);
    tick(2);
    chk("rts_auto", 32'h0, {31'h0, rts_n[2]});
    thr[2] <= 1'b1;
    tick(2);
    chk("rts_auto_off", 32'h1, {31'h0, rts_n[2]});
    $display("test loopback done");
    conclude();
  end
endmodule

bind ums_top ums_props #(.NUM_CH(NUM_CH)) u_props (.mclk(mclk),
  .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .interrupt_force_enable(interrupt_force_enable),
  .carrier_detect_n(carrier_detect_n),
  .terminal_ready_n(terminal_ready_n),
  .request_to_send_n(request_to_send_n),
  .channel_irq_oe_n(channel_irq_oe_n), .serial_tx(serial_tx));
`default_nettype wire

// >>> tb/ums_modem.sv
// modem model answering the control lines of every channel
`timescale 1ns/10ps
`default_nettype none
module ums_modem
#(
  parameter NUM_CH = 4,
  parameter LAT    = 2
)
(
  // clock
  input  wire logic              mclk,
  // control lines from the block
  input  wire logic [NUM_CH-1:0] terminal_ready_n,
  input  wire logic [NUM_CH-1:0] request_to_send_n,
  // status lines to the block
  output var  logic [NUM_CH-1:0] set_ready_n,
  output var  logic [NUM_CH-1:0] clear_to_send_n
);
  // echoes come late on purpose: a wire would hide a stale status read
  logic [2*NUM_CH-1:0] pipe [0:LAT-1] = '{default: '1};
  always @(posedge mclk)
  begin
    pipe[0] <= {request_to_send_n, terminal_ready_n};
    for (int i = 1; i < LAT; i++)
      pipe[i] <= pipe[i-1];
  end
  assign {clear_to_send_n, set_ready_n} = pipe[LAT-1];
endmodule
`default_nettype wire

// >>> tb/ums_top_properties.sv
// port assertions for the modem signal and interrupt pin block
`timescale 1ns/10ps
`default_nettype none
module ums_props
#(
  parameter NUM_CH = 4
)
(
  // clock and reset
  input wire logic              mclk,
  input wire logic              arst_n,
  // bus
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic [31:0]       hrdata,
  // pins
  input wire logic              interrupt_force_enable,
  input wire logic [NUM_CH-1:0] carrier_detect_n,
  input wire logic [NUM_CH-1:0] terminal_ready_n,
  input wire logic [NUM_CH-1:0] request_to_send_n,
  input wire logic [NUM_CH-1:0] channel_irq_oe_n,
  input wire logic [NUM_CH-1:0] serial_tx
);
  // -----
  // helpers
  // -----
  // internal reset leaves two edges late, so checks wait three
  logic [2:0] rel;
  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
      rel <= 3'h0;
    else
      rel <= {rel[1:0], 1'b1};
  // pins are unknown at the very first edge; reset checks start one
  // edge into a reset, once the asynchronous clear has landed
  logic rst_seen = 1'b0;
  always @(posedge mclk)
    rst_seen <= !arst_n;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rel[2]);
  sequence rd_taken;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence wr_taken;
    hsel && hready && htrans[1] && hwrite;
  endsequence
  sequence read_done;
    !hreadyout ##1 hreadyout;
  endsequence
  // -----
  // properties
  // -----
  term_reset_a: assert property (disable iff (1'b0)
    !arst_n && rst_seen |-> terminal_ready_n == '1)
    else $error("dtr active in reset");
  rts_reset_a: assert property (disable iff (1'b0)
    !arst_n && rst_seen |-> request_to_send_n == '1)
    else $error("rts active in reset");
  irq_reset_a: assert property (disable iff (1'b0)
    !arst_n && rst_seen |-> channel_irq_oe_n == '1)
    else $error("irq driven in reset");
  tx_mark_a: assert property (disable iff (1'b0)
    !arst_n && rst_seen |-> serial_tx == '1)
    else $error("tx not marking in reset");
  force_irq_a: assert property (
    interrupt_force_enable |=> channel_irq_oe_n == '0)
    else $error("forced irq pin not driven");
  read_wait_a: assert property (rd_taken |=> read_done)
    else $error("read wait not one cycle");
  write_nowait_a: assert property (wr_taken |=> hreadyout)
    else $error("write stalled");
  carrier_read_a: assert property (
    rd_taken ##0 haddr == 32'h18 |-> ##2 hrdata[31:8] == 24'h0 &&
      hrdata[7] == !$past(carrier_detect_n[0]))
    else $error("carrier status bit wrong");
endmodule
`default_nettype wire
